// file: verilog/ofd_pkg.sv
// package of constants and types for the operand field decoder
package ofd_pkg;
  // register selector encodings (byte registers)
  localparam logic [2:0] OFD_R_ACC   = 3'h1;
  localparam int         OFD_NUM_REG = 8;
  localparam int         OFD_NUM_RP  = 4;
  // pair selector for the 16-bit accumulator
  localparam logic [1:0] OFD_RP_ACC  = 2'h0;
  // short direct window
  localparam logic [15:0] OFD_SADDR_LO = 16'hFE20;
  localparam logic [15:0] OFD_SADDR_HI = 16'hFF1F;
  // special-register window and its excluded block
  localparam logic [15:0] OFD_SFR_LO   = 16'hFF00;
  localparam logic [15:0] OFD_SFR_HI   = 16'hFFFF;
  localparam logic [15:0] OFD_SFR_XLO  = 16'hFFD0;
  localparam logic [15:0] OFD_SFR_XHI  = 16'hFFDF;
  // fixed call window
  localparam logic [15:0] OFD_FCALL_LO = 16'h0800;
  localparam logic [15:0] OFD_FCALL_HI = 16'h0FFF;
  // call table window
  localparam logic [15:0] OFD_TCALL_LO = 16'h0040;
  localparam logic [15:0] OFD_TCALL_HI = 16'h007F;
  // operand widths
  localparam int OFD_BIT_W  = 3;
  localparam int OFD_BYTE_W = 8;
  localparam int OFD_WORD_W = 16;
  localparam int OFD_FCALL_W = 11;
  localparam int OFD_TCALL_W = 5;
  // cpu clock period in ns; one instruction cycle is one period
  localparam int OFD_CLK_NS = 100;
  // flag action codes
  typedef enum logic [2:0] {
    OFD_FL_KEEP    = 3'h0,
    OFD_FL_CLR     = 3'h1,
    OFD_FL_SET     = 3'h2,
    OFD_FL_RESULT  = 3'h3,
    OFD_FL_RESTORE = 3'h4
  } ofd_flag_act_t;
  // operand kinds for the address checker
  typedef enum logic [3:0] {
    OFD_K_SADDR  = 4'h0,
    OFD_K_SADDRP = 4'h1,
    OFD_K_SFR    = 4'h2,
    OFD_K_SFRP   = 4'h3,
    OFD_K_ABS    = 4'h4,
    OFD_K_ABSW   = 4'h5,
    OFD_K_FCALL  = 4'h6,
    OFD_K_TCALL  = 4'h7
  } ofd_kind_t;
  // flag positions in the status word
  localparam int OFD_PSW_W  = 8;
  localparam int OFD_Z_POS  = 6;
  localparam int OFD_AC_POS = 4;
  localparam int OFD_CY_POS = 0;
endpackage

// file: verilog/ofd_operand_field_decoder.sv
// operand field decoder: selectors, address operands, flag updates
//
// Summary of operation
// - byte selector 0-7 picks eight registers, 1=acc
// - pair selector 0-3 picks pairs, 0=acc
// - short direct FE20-FF1F, pair form even only
// - absolute full space, word transfers even only
// - fixed call target limited to 0800-0FFF
// - call table picks even address 0040-007F
// - special-register operands never reach FFD0-FFDF
// - special pair operand: word registers, even only
// - immediates are 3, 8 and 16 bits wide
// - branch offset signed, added to program counter
// - each flag kept, cleared, set or from result
// - fifth action restores flag from saved copy
// - one instruction cycle is one cpu clock
`timescale 1ns/10ps

module ofd_operand_field_decoder
  import ofd_pkg::*;
#(
  parameter logic [255:0] SFR_WORD_MAP = {256{1'b1}} // word-capable sfrs
) (
  input  wire logic                      CLK_I,        // cpu clock
  input  wire logic                      RESET_N_I,    // async reset, low
  input  wire logic                      DEC_VALID_I,  // operand present
  input  wire logic [2:0]                REG_SEL_I,    // byte selector
  input  wire logic [1:0]                REG_PAIR_SEL_I, // pair selector
  input  wire ofd_kind_t                 ADDR_KIND_I,  // address kind
  input  wire logic [15:0]               ADDR_FIELD_I, // raw address field
  input  wire logic [OFD_WORD_W-1:0]     IMM_FIELD_I,  // raw immediate
  input  wire logic [15:0]               PC_I,         // next pc
  input  wire logic [7:0]                BRANCH_OFS_I, // relative offset
  input  wire ofd_flag_act_t             ACT_Z_I,      // zero flag action
  input  wire ofd_flag_act_t             ACT_AC_I,     // half carry action
  input  wire ofd_flag_act_t             ACT_CY_I,     // carry action
  input  wire logic [2:0]                RES_FLAGS_I,  // {z,ac,cy} result
  input  wire logic [OFD_PSW_W-1:0]      SAVED_PSW_I,  // saved status
  input  wire logic                      PSW_LOAD_I,   // write whole psw
  input  wire logic [OFD_PSW_W-1:0]      PSW_DATA_I,   // psw write data
  output logic [OFD_NUM_REG-1:0]         REG_ONEHOT_O, // byte reg select
  output logic                           REG_IS_ACC_O, // accumulator hit
  output logic [OFD_NUM_RP-1:0]          PAIR_ONEHOT_O, // pair select
  output logic                           PAIR_IS_ACC_O, // 16-bit acc hit
  output logic [15:0]                    EFF_ADDR_O,   // effective address
  output logic                           ADDR_OK_O,    // address legal
  output logic [OFD_BIT_W-1:0]           IMM_BIT_O,    // bit position
  output logic [OFD_BYTE_W-1:0]          IMM_BYTE_O,   // byte immediate
  output logic [OFD_WORD_W-1:0]          IMM_WORD_O,   // word immediate
  output logic [15:0]                    BRANCH_TGT_O, // relative target
  output logic [OFD_PSW_W-1:0]           PSW_O,        // status word
  output logic [31:0]                    CYCLE_CNT_O   // instruction cycles
);

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // small pure functions shared by the decode processes

  // inclusive window test, used by several operand kinds;
  // no window here wraps past the top of the space, so a plain
  // pair of compares is enough
  function automatic logic in_win(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  // next value of one status flag under its action code
  // spare codes 5..7 act as keep so that a stray code from a bad
  // decode can never disturb the status word
  function automatic logic flag_next(input ofd_flag_act_t act,
                                     input logic cur,
                                     input logic res,
                                     input logic saved);
    case (act)
      OFD_FL_KEEP:    flag_next = cur;
      OFD_FL_CLR:     flag_next = 1'b0;
      OFD_FL_SET:     flag_next = 1'b1;
      OFD_FL_RESULT:  flag_next = res;
      OFD_FL_RESTORE: flag_next = saved;
      default:        flag_next = cur; // unused codes leave the flag alone
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registered state

  // every output comes straight from one of these flops, so the
  // consumer sees all decoded fields change together on one edge
  logic [OFD_NUM_REG-1:0] reg_oh_ff,  nxt_reg_oh;   // byte select
  logic                   reg_acc_ff, nxt_reg_acc;  // acc flag
  logic [OFD_NUM_RP-1:0]  pair_oh_ff, nxt_pair_oh;  // pair select
  logic                   pair_acc_ff, nxt_pair_acc; // pair acc flag
  logic [15:0]            addr_ff,    nxt_addr;     // effective address
  logic                   ok_ff,      nxt_ok;       // address legal
  logic [OFD_BIT_W-1:0]   bit_ff,     nxt_bit;      // bit immediate
  logic [OFD_BYTE_W-1:0]  byte_ff,    nxt_byte;     // byte immediate
  logic [OFD_WORD_W-1:0]  word_ff,    nxt_word;     // word immediate
  logic [15:0]            tgt_ff,     nxt_tgt;      // branch target
  logic [OFD_PSW_W-1:0]   psw_ff,     nxt_psw;      // status word
  logic [31:0]            cyc_ff,     nxt_cyc;      // cycle counter

  ////////////////////////////////////////////////////////////////////////
  // register selectors
  // byte and pair selectors decode in parallel; both are always legal

  // selectors decode to one-hot; outputs hold between valid operands
  always_comb begin
    nxt_reg_oh   = reg_oh_ff;
    nxt_reg_acc  = reg_acc_ff;
    nxt_pair_oh  = pair_oh_ff;
    nxt_pair_acc = pair_acc_ff;
    // no operand this cycle: keep the last decode on the outputs
    if (DEC_VALID_I) begin
      // byte register decode
      // a selector always hits exactly one register, none is reserved
      nxt_reg_oh   = '0;
      nxt_reg_oh[REG_SEL_I] = 1'b1;
      nxt_reg_acc  = (REG_SEL_I == OFD_R_ACC);
      nxt_pair_oh  = '0;
      nxt_pair_oh[REG_PAIR_SEL_I] = 1'b1;
      nxt_pair_acc = (REG_PAIR_SEL_I == OFD_RP_ACC);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address operands

  // forms the full address and checks it against the operand's window;
  // an illegal operand still forms an address, the caller must gate it
  // the special-register space is taken as the top page less the
  // reserved block; SFR_WORD_MAP marks which of its bytes may be
  // reached as words, so parts with fewer word registers clear bits
  always_comb begin
    nxt_addr = addr_ff;
    nxt_ok   = ok_ff;
    if (DEC_VALID_I) begin
      case (ADDR_KIND_I)
        OFD_K_SADDR: begin
          nxt_addr = ADDR_FIELD_I;
          nxt_ok   = in_win(ADDR_FIELD_I, OFD_SADDR_LO, OFD_SADDR_HI);
        end
        OFD_K_SADDRP: begin
          nxt_addr = ADDR_FIELD_I;
          nxt_ok   = in_win(ADDR_FIELD_I, OFD_SADDR_LO, OFD_SADDR_HI)
                     && !ADDR_FIELD_I[0];
        end
        OFD_K_SFR: begin
          nxt_addr = ADDR_FIELD_I;
          nxt_ok   = in_win(ADDR_FIELD_I, OFD_SFR_LO, OFD_SFR_HI)
                     && !in_win(ADDR_FIELD_I, OFD_SFR_XLO, OFD_SFR_XHI);
        end
        OFD_K_SFRP: begin
          nxt_addr = ADDR_FIELD_I;
          nxt_ok   = in_win(ADDR_FIELD_I, OFD_SFR_LO, OFD_SFR_HI)
                     && !in_win(ADDR_FIELD_I, OFD_SFR_XLO, OFD_SFR_XHI)
                     && !ADDR_FIELD_I[0]
                     && SFR_WORD_MAP[ADDR_FIELD_I[7:0]];
        end
        OFD_K_ABS: begin
          nxt_addr = ADDR_FIELD_I;
          nxt_ok   = 1'b1;
        end
        OFD_K_ABSW: begin
          nxt_addr = ADDR_FIELD_I;
          nxt_ok   = !ADDR_FIELD_I[0];
        end
        OFD_K_FCALL: begin
          // eleven bits placed into the call window
          // or-ing in the low bits cannot leave the window
          nxt_addr = OFD_FCALL_LO | 16'(ADDR_FIELD_I[OFD_FCALL_W-1:0]);
          nxt_ok   = in_win(nxt_addr, OFD_FCALL_LO, OFD_FCALL_HI);
        end
        OFD_K_TCALL: begin
          // five bits pick an even table entry
          // the shift keeps bit 0 clear, so every entry is even
          nxt_addr = OFD_TCALL_LO
                     | 16'({ADDR_FIELD_I[OFD_TCALL_W-1:0], 1'b0});
          nxt_ok   = in_win(nxt_addr, OFD_TCALL_LO, OFD_TCALL_HI);
        end
        default: begin
          // spare kind codes: pass the field through, never legal
          nxt_addr = ADDR_FIELD_I;
          nxt_ok   = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // immediates and relative branch
  // offsets reach 128 back and 127 forward from the given pc

  // slicing costs nothing; registering keeps data outputs clean
  // the three immediate widths are all cut from one field, so a
  // narrower operand simply ignores the upper bits it does not use
  always_comb begin
    nxt_bit  = bit_ff;
    nxt_byte = byte_ff;
    nxt_word = word_ff;
    nxt_tgt  = tgt_ff;
    if (DEC_VALID_I) begin
      nxt_bit  = IMM_FIELD_I[OFD_BIT_W-1:0];
      nxt_byte = IMM_FIELD_I[OFD_BYTE_W-1:0];
      nxt_word = IMM_FIELD_I;
      // sign-extend then add
      // the sum wraps at the top of the space, as the counter does
      nxt_tgt  = PC_I + 16'(signed'(BRANCH_OFS_I));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags
  // three flags follow action codes; the rest of the word is stored

  // a whole-word load has priority; otherwise each flag follows its code
  // bits other than z, ac and cy only change through the whole-word
  // load; the bank, enable and service fields live in those bits
  always_comb begin
    nxt_psw = psw_ff;
    if (PSW_LOAD_I) begin
      nxt_psw = PSW_DATA_I;
    end else if (DEC_VALID_I) begin
      // each flag is handled alone, so one instruction can mix actions
      // per-flag action
      nxt_psw[OFD_Z_POS]  = flag_next(ACT_Z_I, psw_ff[OFD_Z_POS],
                              RES_FLAGS_I[2], SAVED_PSW_I[OFD_Z_POS]);
      nxt_psw[OFD_AC_POS] = flag_next(ACT_AC_I, psw_ff[OFD_AC_POS],
                              RES_FLAGS_I[1], SAVED_PSW_I[OFD_AC_POS]);
      nxt_psw[OFD_CY_POS] = flag_next(ACT_CY_I, psw_ff[OFD_CY_POS],
                              RES_FLAGS_I[0], SAVED_PSW_I[OFD_CY_POS]);
    end
  end

  // one count per clock
  // one instruction cycle is one cpu clock period, so the count times
  // the clock period gives elapsed decode time; 32 bits wrap silently
  always_comb begin
    nxt_cyc = cyc_ff + 32'h00000001;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // all state resets to constants; counter wraps silently
  // reset is asynchronous so outputs are quiet before the clock runs
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      // constants only, so the reset path needs no other logic
      reg_oh_ff   <= '0;
      reg_acc_ff  <= 1'b0;
      pair_oh_ff  <= '0;
      pair_acc_ff <= 1'b0;
      addr_ff     <= 16'h0000;
      ok_ff       <= 1'b0;
      bit_ff      <= '0;
      byte_ff     <= '0;
      word_ff     <= '0;
      tgt_ff      <= 16'h0000;
      psw_ff      <= '0;
      cyc_ff      <= 32'h00000000;
    end else begin
      // every register loads its next value on every edge
      reg_oh_ff   <= nxt_reg_oh;
      reg_acc_ff  <= nxt_reg_acc;
      pair_oh_ff  <= nxt_pair_oh;
      pair_acc_ff <= nxt_pair_acc;
      addr_ff     <= nxt_addr;
      ok_ff       <= nxt_ok;
      bit_ff      <= nxt_bit;
      byte_ff     <= nxt_byte;
      word_ff     <= nxt_word;
      tgt_ff      <= nxt_tgt;
      psw_ff      <= nxt_psw;
      cyc_ff      <= nxt_cyc;
    end
  end

  // outputs straight from flip-flops
  // no logic after the flops keeps output timing independent of decode
  assign REG_ONEHOT_O  = reg_oh_ff;
  assign REG_IS_ACC_O  = reg_acc_ff;
  assign PAIR_ONEHOT_O = pair_oh_ff;
  assign PAIR_IS_ACC_O = pair_acc_ff;
  assign EFF_ADDR_O    = addr_ff;
  assign ADDR_OK_O     = ok_ff;
  assign IMM_BIT_O     = bit_ff;
  assign IMM_BYTE_O    = byte_ff;
  assign IMM_WORD_O    = word_ff;
  assign BRANCH_TGT_O  = tgt_ff;
  assign PSW_O         = psw_ff;
  assign CYCLE_CNT_O   = cyc_ff;

endmodule // ofd_operand_field_decoder

// file: sim/ofd_operand_field_decoder_sva.sv
// checker for operand field decoder output timing and values
`timescale 1ns/10ps
module ofd_operand_field_decoder_sva
  import ofd_pkg::*;
(
  input wire logic          CLK_I,        // clock
  input wire logic          RESET_N_I,    // async reset, low
  input wire logic          DEC_VALID_I,  // operand strobe
  input wire logic          PSW_LOAD_I,   // status load strobe
  input wire logic [2:0]    REG_SEL_I,    // byte selector
  input wire ofd_kind_t     ADDR_KIND_I,  // address kind
  input wire logic [15:0]   ADDR_FIELD_I, // raw address field
  input wire logic [15:0]   PC_I,         // pc for branches
  input wire logic [7:0]    BRANCH_OFS_I, // relative offset
  input wire logic [7:0]    SAVED_PSW_I,  // saved status
  input wire ofd_flag_act_t ACT_Z_I,      // zero flag action
  input wire ofd_flag_act_t ACT_CY_I,     // carry action
  input wire logic [7:0]    REG_ONEHOT_O, // byte select
  input wire logic [7:0]    PSW_O,        // status word
  input wire logic          REG_IS_ACC_O, // accumulator hit
  input wire logic          ADDR_OK_O,    // address legal
  input wire logic [15:0]   EFF_ADDR_O,   // effective address
  input wire logic [15:0]   BRANCH_TGT_O, // branch target
  input wire logic [31:0]   CYCLE_CNT_O   // cycle count
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  logic [15:0] tgt_c; // branch target formed from live inputs
  assign tgt_c = PC_I + {{8{BRANCH_OFS_I[7]}}, BRANCH_OFS_I};
  ////////////////////////////////////////////////////////////////////
  // byte select
  property p_reg_sel;
    DEC_VALID_I |=> REG_ONEHOT_O == (8'h01 << $past(REG_SEL_I))
      && REG_IS_ACC_O == ($past(REG_SEL_I) == 3'h1);
  endproperty
  a_reg_sel: assert property (p_reg_sel)
    else $error("byte select mismatch");
  property p_saddr;
    DEC_VALID_I && ADDR_KIND_I == OFD_K_SADDR |=>
      ADDR_OK_O == ($past(ADDR_FIELD_I) inside {[16'hFE20:16'hFF1F]});
  endproperty
  a_saddr: assert property (p_saddr)
    else $error("short direct legality wrong");
  property p_sfr_hole;
    DEC_VALID_I && ADDR_KIND_I inside {OFD_K_SFR, OFD_K_SFRP}
      && ADDR_FIELD_I inside {[16'hFFD0:16'hFFDF]} |=> !ADDR_OK_O;
  endproperty
  a_sfr_hole: assert property (p_sfr_hole)
    else $error("special operand reached hole");
  property p_absw;
    DEC_VALID_I && ADDR_KIND_I == OFD_K_ABSW |=>
      EFF_ADDR_O == $past(ADDR_FIELD_I) && ADDR_OK_O == !EFF_ADDR_O[0];
  endproperty
  a_absw: assert property (p_absw)
    else $error("absolute word legality wrong");
  property p_fcall;
    DEC_VALID_I && ADDR_KIND_I == OFD_K_FCALL |=> ADDR_OK_O
      && EFF_ADDR_O == (16'h0800 | ($past(ADDR_FIELD_I) & 16'h07FF));
  endproperty
  a_fcall: assert property (p_fcall)
    else $error("fixed call target wrong");
  property p_tcall;
    DEC_VALID_I && ADDR_KIND_I == OFD_K_TCALL |=> ADDR_OK_O
      && EFF_ADDR_O == (16'h0040 | (($past(ADDR_FIELD_I) & 16'h001F) << 1));
  endproperty
  a_tcall: assert property (p_tcall)
    else $error("table call address wrong");
  property p_branch;
    DEC_VALID_I |=> BRANCH_TGT_O == $past(tgt_c);
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch target wrong");
  property p_cy_force;
    DEC_VALID_I && !PSW_LOAD_I && ACT_CY_I inside {OFD_FL_SET, OFD_FL_CLR}
      |=> PSW_O[0] == ($past(ACT_CY_I) == OFD_FL_SET);
  endproperty
  a_cy_force: assert property (p_cy_force)
    else $error("forced carry wrong");
  property p_z_restore;
    DEC_VALID_I && !PSW_LOAD_I && ACT_Z_I == OFD_FL_RESTORE |=>
      (PSW_O & 8'h40) == ($past(SAVED_PSW_I) & 8'h40);
  endproperty
  a_z_restore: assert property (p_z_restore)
    else $error("zero flag restore wrong");
  property p_hold;
    !DEC_VALID_I && !PSW_LOAD_I |=> $stable(PSW_O) && $stable(EFF_ADDR_O);
  endproperty
  a_hold: assert property (p_hold)
    else $error("outputs moved while idle");
  property p_cycle;
    $past(RESET_N_I) |-> CYCLE_CNT_O == $past(CYCLE_CNT_O) + 32'h1;
  endproperty
  a_cycle: assert property (p_cycle)
    else $error("cycle counter step wrong");
  // main scenario coverage
  c_sfrp: cover property (DEC_VALID_I && ADDR_KIND_I == OFD_K_SFRP);
  c_load: cover property (PSW_LOAD_I);
  c_b2b: cover property (DEC_VALID_I ##1 DEC_VALID_I);
endmodule // ofd_operand_field_decoder_sva
bind ofd_operand_field_decoder ofd_operand_field_decoder_sva u_sva (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .DEC_VALID_I(DEC_VALID_I),
  .PSW_LOAD_I(PSW_LOAD_I), .REG_SEL_I(REG_SEL_I),
  .ADDR_KIND_I(ADDR_KIND_I), .ADDR_FIELD_I(ADDR_FIELD_I), .PC_I(PC_I),
  .BRANCH_OFS_I(BRANCH_OFS_I), .SAVED_PSW_I(SAVED_PSW_I),
  .ACT_Z_I(ACT_Z_I), .ACT_CY_I(ACT_CY_I), .REG_ONEHOT_O(REG_ONEHOT_O),
  .PSW_O(PSW_O), .REG_IS_ACC_O(REG_IS_ACC_O), .ADDR_OK_O(ADDR_OK_O),
  .EFF_ADDR_O(EFF_ADDR_O), .BRANCH_TGT_O(BRANCH_TGT_O),
  .CYCLE_CNT_O(CYCLE_CNT_O));

// file: sim/tb.sv
// self-checking bench for the operand field decoder
`timescale 1ns/10ps
module tb;
  import ofd_pkg::*;
  logic clk, rst_n, dv, ld;          // clock, reset, strobes
  logic [2:0] rs, rf, o_bit;         // selector, results, bit imm
  logic [1:0] ps;                    // pair selector
  ofd_kind_t kd;                     // address kind
  ofd_flag_act_t az, aa, ac;         // flag actions
  logic [15:0] fld, imm, pc, o_addr, o_word, o_tgt; // fields
  logic [7:0] ofs, sp, pd, o_reg, o_byte, o_psw;    // bytes
  logic [3:0] o_pair;                // pair one-hot
  logic o_racc, o_pacc, o_ok;        // single flags
  logic [31:0] o_cnt;                // cycle count
  logic [73:0] e_v;                  // expected outputs less status
  logic [7:0] e_psw;                 // expected status word
  logic [31:0] e_cnt;                // expected cycle count
  int err_total, compares;           // counters
  // boundary addresses around every window edge except FF00
  logic [15:0] cf [16] = '{16'hFE1F, 16'hFE20, 16'hFE21, 16'hFF1E,
    16'hFF1F, 16'hFF20, 16'hFFCF, 16'hFFD0, 16'hFFDF, 16'hFFE0,
    16'hFFFE, 16'h0000, 16'hFFFF, 16'h07FF, 16'h0041, 16'h0001};
  wire [81:0] got = {o_reg, o_racc, o_pair, o_pacc, o_addr, o_ok, o_bit,
    o_byte, o_word, o_tgt, o_psw};
  ofd_operand_field_decoder dut (.CLK_I(clk), .RESET_N_I(rst_n),
    .DEC_VALID_I(dv), .REG_SEL_I(rs), .REG_PAIR_SEL_I(ps),
    .ADDR_KIND_I(kd), .ADDR_FIELD_I(fld), .IMM_FIELD_I(imm), .PC_I(pc),
    .BRANCH_OFS_I(ofs), .ACT_Z_I(az), .ACT_AC_I(aa), .ACT_CY_I(ac),
    .RES_FLAGS_I(rf), .SAVED_PSW_I(sp), .PSW_LOAD_I(ld), .PSW_DATA_I(pd),
    .REG_ONEHOT_O(o_reg), .REG_IS_ACC_O(o_racc), .PAIR_ONEHOT_O(o_pair),
    .PAIR_IS_ACC_O(o_pacc), .EFF_ADDR_O(o_addr), .ADDR_OK_O(o_ok),
    .IMM_BIT_O(o_bit), .IMM_BYTE_O(o_byte), .IMM_WORD_O(o_word),
    .BRANCH_TGT_O(o_tgt), .PSW_O(o_psw), .CYCLE_CNT_O(o_cnt));
  ////////////////////////////////////////////////////////////////////
  // expected {address, legal} per kind; spare kinds 8..F are illegal
  function automatic logic [16:0] am(logic [3:0] k, logic [15:0] f);
    logic s;
    s = f >= 16'hFF00 && !(f >= 16'hFFD0 && f <= 16'hFFDF);
    case (k)
      4'h0: return {f, f >= 16'hFE20 && f <= 16'hFF1F};
      4'h1: return {f, f >= 16'hFE20 && f <= 16'hFF1F && !f[0]};
      4'h2: return {f, s};
      4'h3: return {f, s && !f[0]};
      4'h4: return {f, 1'b1};
      4'h5: return {f, !f[0]};
      4'h6: return {16'h0800 | {5'h00, f[10:0]}, 1'b1};
      4'h7: return {16'h0040 | {10'h000, f[4:0], 1'b0}, 1'b1};
      default: return {f, 1'b0};
    endcase
  endfunction
  // expected flag after one action; codes 5..7 keep
  function automatic logic fm(logic [2:0] a, logic c, logic r, logic s);
    case (a)
      3'h1: return 1'b0;
      3'h2: return 1'b1;
      3'h3: return r;
      3'h4: return s;
      default: return c;
    endcase
  endfunction
  task automatic chk();
    compares++;
    if (o_cnt !== e_cnt) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, o_cnt, e_cnt);
    end
    if (got !== {e_v, e_psw}) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, {e_v, e_psw});
    end
  endtask
  // one request per clock; checks the one taken at this edge
  task automatic step(input logic [3:0] k, input logic [15:0] f,
                      input bit fv);
    logic v, l;
    logic [2:0] r, fl, a0, a1, a2;
    logic [1:0] p;
    logic [15:0] im, pv;
    logic [7:0] o, s, d;
    @(posedge clk);
    v = fv | ($urandom_range(0, 3) != 0);
    l = !fv & ($urandom_range(0, 15) == 0);
    {r, p, fl, a0, a1, a2} = 17'($urandom);
    {im, pv} = $urandom;
    {o, s, d} = 24'($urandom);
    dv <= v; ld <= l; rs <= r; ps <= p; rf <= fl; fld <= f;
    kd <= ofd_kind_t'(k); imm <= im; pc <= pv; ofs <= o; sp <= s;
    az <= ofd_flag_act_t'(a0); aa <= ofd_flag_act_t'(a1);
    ac <= ofd_flag_act_t'(a2); pd <= d;
    @(negedge clk);
    e_cnt++;
    chk();
    // psw load beats flag actions
    if (l) e_psw = d;
    else if (v) e_psw = {e_psw[7], fm(a0, e_psw[6], fl[2], s[6]),
      e_psw[5], fm(a1, e_psw[4], fl[1], s[4]), e_psw[3:1],
      fm(a2, e_psw[0], fl[0], s[0])};
    if (v) e_v = {8'h01 << r, r == 3'h1, 4'h1 << p, p == 2'h0, am(k, f),
      im[2:0], im[7:0], im, pv + {{8{o[7]}}, o}};
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0; dv <= 1'b0; ld <= 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    e_v = '0;
    e_psw = '0;
    e_cnt = '0;
    chk();
    @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, far beyond the ~3500 cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end
  initial begin
    {rst_n, dv, ld, rs, rf, ps, fld, imm, pc, ofs, sp, pd} = '0;
    kd = OFD_K_SADDR;
    az = OFD_FL_KEEP;
    aa = OFD_FL_KEEP;
    ac = OFD_FL_KEEP;
    err_total = 0;
    compares = 0;
    void'($urandom(12155));
    do_reset();
    $display("test reset done: %0d compares", compares);
    for (int k = 0; k < 16; k++) begin
      foreach (cf[i]) step(4'(k), cf[i], 1'b1);
    end
    $display("test corners done: %0d errors", err_total);
    repeat (3000) step(4'($urandom_range(0, 15)),
      $urandom_range(0, 1) ? {8'hFF, 8'($urandom)} : 16'($urandom), 0);
    $display("test random done: %0d errors", err_total);
    do_reset();
    repeat (200) step(4'($urandom_range(0, 7)), 16'($urandom), 0);
    $display("test rereset done: %0d errors", err_total);
    final_report();
  end
endmodule // tb
